// file: src/cms_master_clock.sv
/*
  Configuration master clock selector with soft error check sequencing.
  Assumes all inputs come from logic on clk; the generated clock is a
  divided square wave of clk, so frequencies above clk/2 saturate.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_master_clock (
  input wire logic clk,
  input wire logic srst,
  input wire cms_pkg::cms_sel_req_t sel,
  input wire logic config_done,
  input wire logic user_active,
  input wire logic user_route_en,
  input wire cms_pkg::cms_chk_req_t chk,
  output logic config_master_clock,
  output logic user_clock_src,
  output logic sel_reject,
  output logic soft_error_check_busy,
  output logic soft_error_check_refused,
  output logic reload_request,
  output logic soft_error_flag
);
  import cms_pkg::*;

  logic [CNT_W-1:0] half_reg, half_next, pend_reg, pend_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, req_half;
  logic clk_reg, clk_next, user_reg, user_next, route_reg, route_next;
  logic reject_reg, reject_next, code_ok, accept;
  cms_chk_state_t st_reg, st_next;
  logic bad_reg, bad_next, err_reg, err_next, reload_reg, reload_next;
  logic busy_reg, busy_next, refused_reg, refused_next;

  // Decode the selection code against the table of the current mode
  always_comb begin
    code_ok = 1'b0;
    req_half = DEFAULT_HALF;
    if (!sel.choice_given) begin
      code_ok = 1'b1;
    end else if (sel.encrypted) begin
      for (int i = 0; i < NUM_ENC; i++) begin
        if (sel.code == CODE_W'(i)) begin
          code_ok = 1'b1;
          req_half = half_count(ENC_KHZ[i]);
        end
      end
    end else begin
      for (int i = 0; i < NUM_PLAIN; i++) begin
        if (sel.code == CODE_W'(i)) begin
          code_ok = 1'b1;
          req_half = half_count(PLAIN_KHZ[i]);
        end
      end
    end
  end

  // A selection is taken when no choice is given or its code is legal in its mode
  assign accept = sel.valid && code_ok;

  // Divider; a new half period is only taken at a phase boundary
  always_comb begin
    pend_next = accept ? req_half : pend_reg;
    reject_next = sel.valid && !code_ok;
    half_next = half_reg;
    clk_next = clk_reg;
    cnt_next = cnt_reg + 1'b1;
    if (cnt_reg >= half_reg - 1'b1) begin
      cnt_next = '0;
      clk_next = ~clk_reg;
      half_next = pend_next;
    end
    // Routing enable changes only while the clock is low
    route_next = clk_next ? route_reg : user_route_en;
    user_next = clk_next & route_next;
  end

  // Clock generator registers
  always_ff @(posedge clk) begin
    if (srst) begin
      half_reg <= POWERUP_HALF;
      pend_reg <= POWERUP_HALF;
      cnt_reg <= '0;
      clk_reg <= 1'b0;
      user_reg <= 1'b0;
      route_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      half_reg <= half_next;
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
      user_reg <= user_next;
      route_reg <= route_next;
      reject_reg <= reject_next;
    end
  end

  // Soft error check sequencer
  always_comb begin
    st_next = st_reg;
    bad_next = bad_reg;
    reload_next = 1'b0;
    refused_next = 1'b0;
    err_next = err_reg & ~chk.error_clear;
    case (st_reg)
      CHK_IDLE: begin
        if (chk.start) begin
          if (config_done && !user_active) begin
            st_next = CHK_RUN;
          end else begin
            refused_next = 1'b1;
          end
        end
      end
      CHK_RUN: begin
        if (user_active) begin
          st_next = CHK_IDLE;
        end else if (chk.result_valid) begin
          bad_next = chk.result_bad;
          st_next = CHK_DONE;
        end
      end
      CHK_DONE: begin
        st_next = CHK_IDLE;
        if (bad_reg && chk.reload_mode) begin
          reload_next = 1'b1;
        end
        if (bad_reg && !chk.reload_mode) begin
          err_next = 1'b1;
        end
      end
      default: begin
        st_next = CHK_IDLE;
      end
    endcase
    busy_next = (st_next != CHK_IDLE);
  end

  // Checker registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= CHK_IDLE;
      bad_reg <= 1'b0;
      err_reg <= 1'b0;
      reload_reg <= 1'b0;
      busy_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bad_reg <= bad_next;
      err_reg <= err_next;
      reload_reg <= reload_next;
      busy_reg <= busy_next;
      refused_reg <= refused_next;
    end
  end

  // Outputs come straight from their registers
  assign config_master_clock = clk_reg;
  assign user_clock_src = user_reg;
  assign sel_reject = reject_reg;
  assign soft_error_check_busy = busy_reg;
  assign soft_error_check_refused = refused_reg;
  assign reload_request = reload_reg;
  assign soft_error_flag = err_reg;

  // Properties of the divider and the check sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  powerup_rate_a: assert property ($fell(srst) |-> half_reg == POWERUP_HALF)
    else $error("Power-up half period wrong");
  switch_take_a: assert property (accept |=> pend_reg == $past(req_half))
    else $error("Accepted selection not stored");
  default_rate_a: assert property (sel.valid && !sel.choice_given
    |=> pend_reg == DEFAULT_HALF)
    else $error("Default frequency not chosen");
  plain_range_a: assert property (sel.valid && !sel.encrypted
    && sel.choice_given
    |=> reject_reg == ($past(sel.code) >= CODE_W'(NUM_PLAIN)))
    else $error("Plain code acceptance wrong");
  enc_range_a: assert property (sel.valid && sel.encrypted
    && sel.choice_given
    |=> reject_reg == ($past(sel.code) >= CODE_W'(NUM_ENC)))
    else $error("Encrypted code acceptance wrong");
  clock_runs_a: assert property (cnt_reg == '0 && clk_reg
    |-> ##[1:130] !clk_reg)
    else $error("Master clock stalled");
  user_route_a: assert property (user_reg |-> clk_reg)
    else $error("User clock high while master low");
  check_gate_a: assert property ($rose(busy_reg)
    |-> $past(config_done) && !$past(user_active))
    else $error("Check started while not allowed");
  error_out_a: assert property (st_reg == CHK_DONE && bad_reg
    |=> (reload_reg || err_reg))
    else $error("Soft error not reported");
  no_short_a: assert property (cnt_reg != '0
    |-> $stable(clk_reg) && $stable(half_reg))
    else $error("Phase shortened");
  refuse_pulse_a: assert property (chk.start && st_reg == CHK_IDLE
    && !(config_done && !user_active) |=> soft_error_check_refused)
    else $error("Disallowed check start not refused");
  check_abort_a: assert property (st_reg == CHK_RUN && user_active
    |=> !busy_reg)
    else $error("Check kept running under active user logic");
  flag_sticky_a: assert property (err_reg && !chk.error_clear
    |=> err_reg)
    else $error("Soft error flag lost without clear");
  reload_pulse_a: assert property (reload_reg |=> !reload_reg)
    else $error("Reload request longer than one cycle");

  // Main scenarios worth seeing
  switch_c: cover property (accept ##[1:60] $changed(half_reg));
  reload_c: cover property (reload_reg);
  refuse_c: cover property (soft_error_check_refused);
  abort_c: cover property (st_reg == CHK_RUN && user_active ##1 !busy_reg);
  flag_c: cover property ($rose(soft_error_flag));
endmodule
`default_nettype wire

// file: src/cms_pkg.sv
/*
  Constants, request carriers and state codes for the configuration
  master clock selector.
  Assumes a single 125 MHz system clock.
*/
package cms_pkg;
  // System clock rate
  localparam int CLK_KHZ = 125000;
  // Fixed power-up and default frequencies
  localparam int POWERUP_KHZ = 3100;
  localparam int DEFAULT_KHZ = 2500;
  localparam int NUM_PLAIN = 18;
  localparam int NUM_ENC = 3;
  localparam int CODE_W = 5;
  localparam int CNT_W = 8;
  // Selectable frequencies, index is the selection code
  localparam int PLAIN_KHZ [NUM_PLAIN] = '{2500, 4300, 5400, 6900, 8100,
    9200, 10000, 13000, 15000, 20000, 26000, 30000, 34000, 41000, 45000,
    55000, 60000, 130000};
  localparam int ENC_KHZ [NUM_ENC] = '{2500, 5400, 10000};

  // Half period in system cycles, rounded down, never below one
  function automatic logic [CNT_W-1:0] half_count(input int khz);
    int c;
    c = CLK_KHZ / (2 * khz);
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] POWERUP_HALF = half_count(POWERUP_KHZ);
  localparam logic [CNT_W-1:0] DEFAULT_HALF = half_count(DEFAULT_KHZ);

  // Clock-selection bits from the bitstream
  typedef struct packed {
    logic valid;
    logic choice_given;
    logic encrypted;
    logic [CODE_W-1:0] code;
  } cms_sel_req_t;

  // Soft error check control and result
  typedef struct packed {
    logic start;
    logic result_valid;
    logic result_bad;
    logic reload_mode;
    logic error_clear;
  } cms_chk_req_t;

  typedef enum logic [2:0] {
    CHK_IDLE = 3'b001,
    CHK_RUN = 3'b010,
    CHK_DONE = 3'b100
  } cms_chk_state_t;
endpackage

// file: tb/cms_src_model.sv
/*
  Bitstream source model: presents the clock-selection bits.
  Assumes the bench raises send for one cycle from a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_src_model (
  input wire logic send,
  input wire logic given,
  input wire logic enc,
  input wire logic [4:0] code,
  output cms_pkg::cms_sel_req_t sel
);
  import cms_pkg::*;
  // Outside the pulse the code lines show no stale value
  always_comb begin
    sel.valid = send;
    sel.choice_given = given;
    sel.encrypted = enc;
    sel.code = send ? code : ~code;
  end
endmodule
`default_nettype wire

// file: tb/cms_master_clock_bench.sv
/*
  Self-checking bench for the master clock selector.
  Assumes inputs change on falling edges and the design's reset contract.
*/
`timescale 1ns/1ps
`default_nettype none
module cms_master_clock_bench;
  import cms_pkg::*;
  logic clk = 0, srst = 1, send = 0, given = 0, enc = 0;
  logic [4:0] code = 5'h00;
  logic config_done = 0, user_active = 0, user_route_en = 0;
  cms_chk_req_t chk = '0;
  cms_sel_req_t sel;
  logic cmc, ucs, rej, busy, refused, reload, flag;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  cms_src_model src (.send(send), .given(given), .enc(enc), .code(code),
    .sel(sel));
  cms_master_clock dut (.clk(clk), .srst(srst), .sel(sel),
    .config_done(config_done), .user_active(user_active),
    .user_route_en(user_route_en), .chk(chk), .config_master_clock(cmc),
    .user_clock_src(ucs), .sel_reject(rej), .soft_error_check_busy(busy),
    .soft_error_check_refused(refused), .reload_request(reload),
    .soft_error_flag(flag));
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  // Cycles until the master clock next changes level
  task automatic tog(output logic [7:0] n);
    logic v;
    v = cmc;
    n = 8'h00;
    do begin
      @(negedge clk);
      n++;
    end while (cmc === v && n < 8'hFA);
  endtask
  // Third phase after a change shows the settled half period
  task automatic half(int khz);
    logic [7:0] n;
    repeat (3) tog(n);
    check("half period", n, 8'(CLK_KHZ / (2 * khz)));
  endtask
  task automatic pick(logic g, logic e, logic [4:0] c, logic exp_rej);
    logic r;
    given = g;
    enc = e;
    code = c;
    send = 1;
    @(negedge clk);
    send = 0;
    r = rej;
    @(negedge clk);
    r |= rej;
    check("sel_reject", 8'(r), 8'(exp_rej));
  endtask
  // One check request, then {refused, reload, busy, flag} seen
  task automatic go(cms_chk_req_t c, logic [3:0] exp);
    logic [3:0] s;
    chk = c;
    s = 4'h0;
    repeat (3) begin
      @(negedge clk);
      // Pulses last one cycle; reload_mode and result_bad stay as levels
      chk.start = 1'b0;
      chk.result_valid = 1'b0;
      chk.error_clear = 1'b0;
      s |= {refused, reload, 2'b00};
    end
    s[1] = busy;
    s[0] = flag;
    check("check outputs", 8'(s), 8'(exp));
  endtask
  task automatic t_select();
    half(POWERUP_KHZ);
    pick(0, 0, 5'h00, 0);
    half(DEFAULT_KHZ);
    pick(1, 0, 5'h06, 0);
    half(PLAIN_KHZ[6]);
    pick(1, 0, 5'h12, 1);
    half(PLAIN_KHZ[6]);
    pick(1, 1, 5'h01, 0);
    half(ENC_KHZ[1]);
    pick(1, 1, 5'h03, 1);
    $display("selection test done");
  endtask
  task automatic t_route();
    logic [7:0] m;
    // Routing off: the user clock source stays low
    m = 8'h00;
    repeat (40) begin
      @(negedge clk);
      m += 8'(ucs);
    end
    check("user_clock_src off", m, 8'h00);
    config_done = 1;
    user_route_en = 1;
    half(ENC_KHZ[1]);
    m = 8'h00;
    repeat (40) begin
      @(negedge clk);
      m += 8'(ucs !== cmc);
    end
    check("user_clock_src", m, 8'h00);
    $display("route test done");
  endtask
  task automatic t_check();
    user_active = 1;
    go('{start: 1, default: 0}, 4'h8);
    user_active = 0;
    config_done = 0;
    go('{start: 1, default: 0}, 4'h8);
    config_done = 1;
    go('{start: 1, default: 0}, 4'h2);
    go('{result_valid: 1, result_bad: 1, reload_mode: 1, default: 0},
      4'h4);
    go('{start: 1, default: 0}, 4'h2);
    go('{result_valid: 1, result_bad: 1, default: 0}, 4'h1);
    go('{error_clear: 1, default: 0}, 4'h0);
    // A running check is dropped once user logic becomes active
    go('{start: 1, default: 0}, 4'h2);
    user_active = 1;
    go('{default: 0}, 4'h0);
    user_active = 0;
    $display("soft error check test done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 0;
    t_select();
    t_route();
    t_check();
    wrap_up();
  end
endmodule
`default_nettype wire
